// File: rtl/bxms_pkg.sv
// Constants, pin indices and mode type for the bus transceiver mode/status block
package bxms_pkg;
    // Clock
    localparam int CLK_PERIOD_NS = 50;
    // Detection and hold times in ns (plain defaults)
    localparam int T_ACT_NS = 100;
    localparam int T_IDLE_NS = 200;
    localparam int T_GTS_NS = 20000;
    // Least times round up, never below one cycle
    localparam int ACT_CYC = (T_ACT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IDLE_CYC = (T_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GTS_CYC = (T_GTS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;
    // Synchronised pin vector layout
    localparam int NPIN = 11;
    localparam int P_AWAKE = 0;
    localparam int P_MODEB = 1;
    localparam int P_TXG = 2;
    localparam int P_GUARD = 3;
    localparam int P_ACT = 4;
    localparam int P_LOW = 5;
    localparam int P_HIGH = 6;
    localparam int P_LWAKE = 7;
    localparam int P_RWAKE = 8;
    localparam int P_ERR = 9;
    localparam int P_PWR = 10;
    // Reset levels mirror the pin pulls: tx gate high, rest low
    localparam logic [NPIN-1:0] PIN_RST = 11'h004;
    // Transmit FIFO shape
    localparam int FIFO_W = 1;
    localparam int FIFO_D = 16;
    // Operating modes
    typedef enum logic [2:0] {
        M_POWEROFF, M_STANDBY, M_GOTOSLEEP, M_SLEEP, M_RXONLY, M_NORMAL
    } bxms_mode_e;
endpackage

// File: rtl/bxms_top.sv
// Mode control, activity detection, status pin and transmit gating of the transceiver
//
// Notes on behaviour
// - Six modes: normal, rx-only, three low-power, off
// - mode_ctrl_b active high, pulled low
// - tx_gate_n high disables transmitter, pulled up
// - guardian_gate low disables transmitter, pulled low
// - awake_request low selects a low-power mode
// - bus_activity_n low while bus activity recognised
// - Error reporting drives diag_flag_n low on error
// - Activity/idle detection only in normal-power modes
// - Activity held long enough: flag low, data released
// - Released data follows low/high thresholds
// - Idle held long enough: flag high, data high
// - Status pin function set by pins, not mode
// - awake_request low: status shows pending wake-up
// - Both pins high: status shows error alert
// - Rx-only after wake: low remote, high local
// - Rx-only from normal keeps reporting error
// - After normal reached, error status persists until low power
// - Status pin floats in power-off
// - Two pins decode the four host-selected modes
// - Sleep only after go-to-sleep held long enough
// - Low-power: activity and data low flag wake
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Small FIFO, registered ready on the filling side
module bxms_fifo #(
    parameter int W = 1,
    parameter int D = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Fill side
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Drain side
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];  // Storage
    logic [AW-1:0] wp_r, rp_r;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    assign out_valid = cnt_r != '0;
    assign out_data = mem[rp_r];
    // Storage writes carry no reset
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end
    // Pointers; wrap relies on D being a power of two
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            in_ready <= 1'b0;
        end else begin
            wp_r <= wp_r + AW'(push);
            rp_r <= rp_r + AW'(pop);
            cnt_r <= cnt_nxt;
            in_ready <= cnt_nxt != (AW+1)'(D);
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module bxms_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Host control pins
    input wire logic awake_request,
    input wire logic mode_ctrl_b,
    input wire logic tx_gate_n,
    input wire logic guardian_gate,
    // Transmit stream from host
    input wire logic [bxms_pkg::FIFO_W-1:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    // Analog front-end results
    input wire logic bus_act_above,
    input wire logic bus_below_low,
    input wire logic bus_above_high,
    input wire logic local_wake_det,
    input wire logic remote_wake_det,
    input wire logic error_det,
    input wire logic power_ok,
    // Host-facing outputs
    output logic rx_bit_out,
    output logic bus_activity_n,
    output logic bus_activity_oe,
    output logic diag_flag_n,
    output logic diag_flag_oe,
    // Transmitter and mode
    output logic tx_drive_en,
    output logic [bxms_pkg::FIFO_W-1:0] tx_drive_data,
    output logic [2:0] mode_state
);
    import bxms_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Three-stage pin synchroniser; change taken when stages 2 and 3 agree
    logic [NPIN-1:0] raw, s1_r, s2_r, s3_r, pin_r, pin_nxt;
    assign raw = {power_ok, error_det, remote_wake_det, local_wake_det,
                  bus_above_high, bus_below_low, bus_act_above,
                  guardian_gate, tx_gate_n, mode_ctrl_b, awake_request};
    assign pin_nxt = (s2_r & s3_r) | (pin_r & (s2_r | s3_r));
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s1_r <= PIN_RST;  // Pull levels
            s2_r <= PIN_RST;
            s3_r <= PIN_RST;
            pin_r <= PIN_RST;
        end else begin
            s1_r <= raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            pin_r <= pin_nxt;
        end
    end

    // Named views of the filtered pins
    wire awk = pin_r[P_AWAKE];
    wire mdb = pin_r[P_MODEB];
    wire wake_ev = pin_r[P_LWAKE] | pin_r[P_RWAKE];

    ////////////////////////////////////////////////////////////////////////////
    // Mode state
    bxms_mode_e mode_r, mode_nxt, pin_mode;
    logic [CNT_W-1:0] gts_cnt_r;
    logic gts_done;
    logic lowp, npow;
    // Host selection from the two pins
    assign pin_mode = awk ? (mdb ? M_NORMAL : M_RXONLY)
                          : (mdb ? M_GOTOSLEEP : M_STANDBY);
    assign gts_done = gts_cnt_r >= CNT_W'(GTS_CYC);
    assign lowp = mode_r == M_STANDBY || mode_r == M_GOTOSLEEP || mode_r == M_SLEEP;
    assign npow = mode_r == M_NORMAL || mode_r == M_RXONLY;

    // Next mode; power loss overrides everything
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            M_POWEROFF: mode_nxt = M_STANDBY;
            M_SLEEP: begin
                // Sleep is left by raising awake_request or by a wake-up
                if (awk) begin
                    mode_nxt = pin_mode;
                end else if (wake_ev) begin
                    mode_nxt = M_STANDBY;
                end
            end
            M_GOTOSLEEP: begin
                // Hold time must pass before Sleep
                if (pin_mode != M_GOTOSLEEP) begin
                    mode_nxt = pin_mode;
                end else if (gts_done) begin
                    mode_nxt = M_SLEEP;
                end
            end
            M_STANDBY, M_RXONLY, M_NORMAL: mode_nxt = pin_mode;
            default: mode_nxt = M_POWEROFF;
        endcase
        if (!pin_r[P_PWR]) begin
            mode_nxt = M_POWEROFF;
        end
    end

    // Mode register and go-to-sleep hold counter
    always_ff @(posedge clk) begin
        if (!rstn) begin
            mode_r <= M_POWEROFF;
            gts_cnt_r <= '0;
        end else begin
            mode_r <= mode_nxt;
            // Counter restarts whenever the combination lapses
            if (mode_r == M_GOTOSLEEP && pin_mode == M_GOTOSLEEP && !gts_done) begin
                gts_cnt_r <= gts_cnt_r + CNT_W'(1);
            end else if (mode_r != M_GOTOSLEEP || pin_mode != M_GOTOSLEEP) begin
                gts_cnt_r <= '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wake-up bookkeeping and status pin source
    logic wake_r, remote_r, errsel_r;
    logic wake_clr;
    // Wake flag clears on entering Sleep or on reaching Normal
    assign wake_clr = (mode_r == M_GOTOSLEEP && mode_nxt == M_SLEEP) || mode_r == M_NORMAL;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wake_r <= 1'b0;
            remote_r <= 1'b0;
            errsel_r <= 1'b0;
        end else begin
            // A low-power wake-up in the Sleep-entry clearing cycle still sets the flag
            if (lowp && wake_ev) begin
                wake_r <= 1'b1;
                remote_r <= pin_r[P_RWAKE];
            end else if (wake_clr) begin
                wake_r <= 1'b0;
                remote_r <= 1'b0;
            end
            // Normal reached: error reporting sticks until low power
            if (mode_r == M_NORMAL) begin
                errsel_r <= 1'b1;
            end else if (lowp) begin
                errsel_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Activity and idle qualification
    logic [CNT_W-1:0] act_cnt_r, idle_cnt_r;
    logic active_r;
    logic act_hit, idle_hit;
    wire above = pin_r[P_ACT];
    assign act_hit = npow && above && act_cnt_r == CNT_W'(ACT_CYC - 1);
    assign idle_hit = npow && !above && idle_cnt_r == CNT_W'(IDLE_CYC - 1);
    always_ff @(posedge clk) begin
        if (!rstn) begin
            act_cnt_r <= '0;
            idle_cnt_r <= '0;
            active_r <= 1'b0;
        end else begin
            // Each counter restarts once its condition lapses
            act_cnt_r <= (npow && above && !act_hit) ? act_cnt_r + CNT_W'(1) : '0;
            idle_cnt_r <= (npow && !above && !idle_hit) ? idle_cnt_r + CNT_W'(1) : '0;
            if (!npow) begin
                active_r <= 1'b0;
            end else if (act_hit) begin
                active_r <= 1'b1;
            end else if (idle_hit) begin
                active_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output selection
    logic rx_nxt, act_n_nxt, diag_nxt, tx_en_nxt;
    logic [FIFO_W-1:0] fifo_q;
    logic fifo_v;
    wire bus_below_low_f = pin_r[P_LOW];
    wire bus_above_high_f = pin_r[P_HIGH];
    // Data follows thresholds only while activity stands; in low power it shows the wake flag, else held high
    assign rx_nxt = (mode_r == M_POWEROFF) ? 1'b1 :
                    lowp ? !wake_r :
                    !active_r ? 1'b1 :
                    bus_below_low_f ? 1'b0 :
                    bus_above_high_f ? 1'b1 : rx_bit_out;
    assign act_n_nxt = lowp ? !wake_r : !active_r;
    // Status source picked from the pins, not from the mode
    assign diag_nxt = !awk ? !wake_r :
                      mdb ? !pin_r[P_ERR] :
                      errsel_r ? !pin_r[P_ERR] : !remote_r;
    assign tx_en_nxt = mode_r == M_NORMAL && !pin_r[P_TXG] && pin_r[P_GUARD];

    // Transmit FIFO drains only while the transmitter may drive
    bxms_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
        .clk(clk),
        .rstn(rstn),
        .in_data(tx_data),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .out_data(fifo_q),
        .out_valid(fifo_v),
        .out_ready(tx_en_nxt)
    );

    // Registered outputs
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rx_bit_out <= 1'b1;
            bus_activity_n <= 1'b1;
            bus_activity_oe <= 1'b0;
            diag_flag_n <= 1'b1;
            diag_flag_oe <= 1'b0;
            tx_drive_en <= 1'b0;
            tx_drive_data <= '1;
            mode_state <= 3'h0;
        end else begin
            rx_bit_out <= rx_nxt;
            bus_activity_n <= act_n_nxt;
            bus_activity_oe <= mode_r != M_POWEROFF;
            diag_flag_n <= diag_nxt;
            diag_flag_oe <= mode_r != M_POWEROFF;
            tx_drive_en <= tx_en_nxt && fifo_v;
            tx_drive_data <= fifo_v ? fifo_q : '1;
            mode_state <= mode_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_txg_blocks: assert property (@(posedge clk) disable iff (!rstn)
        pin_r[P_TXG] |=> !tx_drive_en) else $error("tx on with gate high");
    a_guard_blocks: assert property (@(posedge clk) disable iff (!rstn)
        !pin_r[P_GUARD] |=> !tx_drive_en) else $error("tx on with guard low");
    a_tx_mode_only: assert property (@(posedge clk) disable iff (!rstn)
        mode_r != M_NORMAL |=> !tx_drive_en) else $error("tx on outside normal");
    a_sleep_hold: assert property (@(posedge clk) disable iff (!rstn)
        (mode_r == M_GOTOSLEEP && mode_nxt == M_SLEEP) |-> gts_cnt_r == CNT_W'(GTS_CYC))
        else $error("sleep entered early");
    a_act_qual: assert property (@(posedge clk) disable iff (!rstn)
        $rose(active_r) |-> $past(act_cnt_r) == CNT_W'(ACT_CYC - 1) && $past(above))
        else $error("activity qualified early");
    a_idle_qual: assert property (@(posedge clk) disable iff (!rstn)
        ($fell(active_r) && $past(npow)) |-> $past(idle_cnt_r) == CNT_W'(IDLE_CYC - 1))
        else $error("idle qualified early");
    a_det_normal: assert property (@(posedge clk) disable iff (!rstn)
        !npow |=> !active_r) else $error("activity outside normal power");
    a_act_pin: assert property (@(posedge clk) disable iff (!rstn)
        npow |=> bus_activity_n == !$past(active_r)) else $error("activity pin wrong");
    a_off_float: assert property (@(posedge clk) disable iff (!rstn)
        mode_r == M_POWEROFF |=> !diag_flag_oe && !bus_activity_oe)
        else $error("status driven in power-off");
    a_err_alert: assert property (@(posedge clk) disable iff (!rstn)
        (awk && mdb) |=> diag_flag_n == !$past(pin_r[P_ERR])) else $error("error alert wrong");
    a_wake_report: assert property (@(posedge clk) disable iff (!rstn)
        !awk |=> diag_flag_n == !$past(wake_r)) else $error("wake report wrong");
    a_idle_rx_high: assert property (@(posedge clk) disable iff (!rstn)
        (npow && !active_r) |=> rx_bit_out) else $error("rx low while idle");
endmodule

// File: tb/bxms_host_model.sv
// Host controller model driving the mode, gate and transmit pins
`timescale 1ns/1ps
module bxms_host_model (
    // Clock
    input wire logic clk,
    // Host control pins
    output logic awake_request,
    output logic mode_ctrl_b,
    output logic tx_gate_n,
    output logic guardian_gate,
    // Transmit stream
    output logic [bxms_pkg::FIFO_W-1:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready
);
    import bxms_pkg::*;
    // Levels applied: guard, gate, mode, awake (high to low bit)
    logic [3:0] lvl_r = 4'h4;
    // Low while the host leaves all its pins floating
    logic drv_r = 1'b0;
    initial begin
        tx_valid = 1'b0;
        tx_data = '0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Floating pins settle at their pull levels, never at the last value
    assign awake_request = drv_r ? lvl_r[0] : 1'b0;
    assign mode_ctrl_b = drv_r ? lvl_r[1] : 1'b0;
    assign tx_gate_n = drv_r ? lvl_r[2] : 1'b1;
    assign guardian_gate = drv_r ? lvl_r[3] : 1'b0;
    ////////////////////////////////////////////////////////////////////////////
    // Select a mode, then wait out the pin filter and the mode update
    task automatic set_mode(input logic aw, input logic mb);
        @(negedge clk);
        drv_r = 1'b1;
        lvl_r[1:0] = {mb, aw};
        repeat (10) @(negedge clk);
    endtask
    // Transmit gate and guardian levels
    task automatic set_gates(input logic gn, input logic gd);
        @(negedge clk);
        drv_r = 1'b1;
        lvl_r[3:2] = {gd, gn};
    endtask
    // One word; held across the edge that sees ready, ok low if refused
    task automatic push(input logic b, output logic ok);
        @(negedge clk);
        ok = tx_ready;
        if (ok === 1'b1) begin
            tx_valid = 1'b1;
            tx_data = b;
            @(negedge clk);
            tx_valid = 1'b0;
            tx_data = ~b;
        end
    endtask
endmodule

// File: tb/bxms_top_bench.sv
// Self-checking bench for the transceiver mode and status block
`timescale 1ns/1ps
module bxms_top_bench;
    import bxms_pkg::*;
    // Clock, reset and front-end stand-ins
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic act, blow, bhigh, lwake, rwake, err, pwr;
    // Host pins and design outputs
    logic awake_request, mode_ctrl_b, tx_gate_n, guardian_gate;
    logic [FIFO_W-1:0] tx_data;
    logic [FIFO_W-1:0] tx_drive_data;
    logic tx_valid, tx_ready, rx_bit_out, bus_activity_n, bus_activity_oe;
    logic diag_flag_n, diag_flag_oe, tx_drive_en;
    logic [2:0] mode_state;
    // Bookkeeping
    int bad_count = 0;
    int n_tests = 0;
    int n_tx = 0;
    int acc = 0;
    int cyc = 0;
    logic ok;
    logic [FIFO_W-1:0] exp_q[$];
    // Pin pair and mode expected: {awake, mode_b, mode}
    logic [4:0] tbl [4] = '{5'h1D, 5'h14, 5'h01, 5'h0A};

    always #25 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    bxms_top bxms_top_inst (.clk(clk), .rstn(rstn), .awake_request(awake_request),
        .mode_ctrl_b(mode_ctrl_b), .tx_gate_n(tx_gate_n), .guardian_gate(guardian_gate),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .bus_act_above(act), .bus_below_low(blow), .bus_above_high(bhigh),
        .local_wake_det(lwake), .remote_wake_det(rwake), .error_det(err),
        .power_ok(pwr), .rx_bit_out(rx_bit_out), .bus_activity_n(bus_activity_n),
        .bus_activity_oe(bus_activity_oe), .diag_flag_n(diag_flag_n),
        .diag_flag_oe(diag_flag_oe), .tx_drive_en(tx_drive_en),
        .tx_drive_data(tx_drive_data), .mode_state(mode_state));
    bxms_host_model bxms_host_model_inst (.clk(clk), .awake_request(awake_request),
        .mode_ctrl_b(mode_ctrl_b), .tx_gate_n(tx_gate_n), .guardian_gate(guardian_gate),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
    ////////////////////////////////////////////////////////////////////////////
    // Compare one value, count it, report a difference at once
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    // Let a number of cycles pass, ending on a falling edge
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Wake detector pulse, longer than the pin filter can lose
    task automatic wake(input logic remote);
        {lwake, rwake} = remote ? 2'h1 : 2'h2;
        wt(5);
        {lwake, rwake} = 2'h0;
        wt(8);
    endtask
    // Print the counts and the verdict, then stop
    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Every transmitted bit must be the next one queued, in order
    always @(negedge clk) begin
        if (tx_drive_en === 1'b1) begin
            n_tx++;
            chk(8'(tx_drive_data), 8'(exp_q.pop_front()));
        end
    end
    // Hang guard, well above the run's length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            chk(8'h00, 8'h01);
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {act, blow, bhigh, lwake, rwake, err, pwr} = 7'h00;
        wt(6);
        chk(8'(mode_state), 8'(M_POWEROFF));
        chk(8'(diag_flag_oe), 8'h00);
        chk(8'(rx_bit_out), 8'h01);
        rstn = 1'b1;
        // Power arrives while every host pin floats
        pwr = 1'b1;
        wt(10);
        chk(8'(mode_state), 8'(M_STANDBY));
        chk(8'(diag_flag_n), 8'h01);
        chk(8'(tx_drive_en), 8'h00);
        chk(8'(diag_flag_oe), 8'h01);
        chk(8'(bus_activity_oe), 8'h01);
        // Bus activity is not looked at in low power
        {act, blow, bhigh} = 3'h5;
        wt(10);
        chk(8'(bus_activity_n), 8'h01);
        {act, blow, bhigh} = 3'h0;
        // Walk the four pin-selected modes
        for (int i = 0; i < 4; i++) begin
            bxms_host_model_inst.set_mode(tbl[i][4], tbl[i][3]);
            chk(8'(mode_state), 8'(tbl[i][2:0]));
        end
        // Go-to-sleep must be held its full time before Sleep
        wt(300);
        chk(8'(mode_state), 8'(M_GOTOSLEEP));
        wt(150);
        chk(8'(mode_state), 8'(M_SLEEP));
        // Local wake in Sleep, then ask for its source
        wake(1'b0);
        chk(8'(diag_flag_n), 8'h00);
        chk(8'(bus_activity_n), 8'h00);
        chk(8'(rx_bit_out), 8'h00);
        bxms_host_model_inst.set_mode(1'b1, 1'b0);
        chk(8'(mode_state), 8'(M_RXONLY));
        chk(8'(diag_flag_n), 8'h01);
        // Error alert in Normal
        bxms_host_model_inst.set_mode(1'b1, 1'b1);
        err = 1'b1;
        wt(10);
        chk(8'(diag_flag_n), 8'h00);
        err = 1'b0;
        wt(10);
        chk(8'(diag_flag_n), 8'h01);
        // Remote wake in Standby, then its source in Receive-only
        bxms_host_model_inst.set_mode(1'b0, 1'b0);
        chk(8'(diag_flag_n), 8'h01);
        wake(1'b1);
        chk(8'(diag_flag_n), 8'h00);
        bxms_host_model_inst.set_mode(1'b1, 1'b0);
        chk(8'(diag_flag_n), 8'h00);
        // Via Normal the status pin stays on error reporting
        bxms_host_model_inst.set_mode(1'b1, 1'b1);
        bxms_host_model_inst.set_mode(1'b1, 1'b0);
        chk(8'(diag_flag_n), 8'h01);
        err = 1'b1;
        wt(10);
        chk(8'(diag_flag_n), 8'h00);
        err = 1'b0;
        bxms_host_model_inst.set_mode(1'b1, 1'b1);
        // Activity, data following thresholds, short lapse, then idle
        {act, blow, bhigh} = 3'h5;
        wt(10);
        chk(8'(bus_activity_n), 8'h00);
        chk(8'(rx_bit_out), 8'h01);
        {act, blow, bhigh} = 3'h6;
        wt(8);
        chk(8'(rx_bit_out), 8'h00);
        {act, blow, bhigh} = 3'h2;
        wt(3);
        {act, blow, bhigh} = 3'h6;
        wt(8);
        chk(8'(bus_activity_n), 8'h00);
        // Data back high through the upper threshold while activity stands
        {act, blow, bhigh} = 3'h5;
        wt(8);
        chk(8'(rx_bit_out), 8'h01);
        {act, blow, bhigh} = 3'h2;
        wt(10);
        chk(8'(bus_activity_n), 8'h01);
        chk(8'(rx_bit_out), 8'h01);
        blow = 1'b0;
        // Fill the buffer with the gate closed until it refuses
        bxms_host_model_inst.set_gates(1'b1, 1'b1);
        for (int i = 0; i < 17; i++) begin
            bxms_host_model_inst.push(i[0], ok);
            if (ok === 1'b1) begin
                acc++;
                exp_q.push_back(i[0]);
            end
        end
        chk(8'(acc), 8'h10);
        chk(8'(tx_ready), 8'h00);
        chk(8'(n_tx), 8'h00);
        bxms_host_model_inst.set_gates(1'b0, 1'b0);
        wt(20);
        chk(8'(n_tx), 8'h00);
        // Both gates open: the whole buffer drains in order
        bxms_host_model_inst.set_gates(1'b0, 1'b1);
        wt(40);
        chk(8'(n_tx), 8'h10);
        chk(8'(tx_ready), 8'h01);
        // Receive-only holds a word back until Normal returns
        bxms_host_model_inst.set_mode(1'b1, 1'b0);
        bxms_host_model_inst.push(1'b0, ok);
        chk(8'(ok), 8'h01);
        exp_q.push_back(1'b0);
        wt(20);
        chk(8'(n_tx), 8'h10);
        bxms_host_model_inst.set_mode(1'b1, 1'b1);
        chk(8'(n_tx), 8'h11);
        // Supply loss: everything released
        pwr = 1'b0;
        wt(10);
        chk(8'(mode_state), 8'(M_POWEROFF));
        chk(8'(diag_flag_oe), 8'h00);
        chk(8'(bus_activity_oe), 8'h00);
        chk(8'(rx_bit_out), 8'h01);
        chk(8'(tx_drive_en), 8'h00);
        summarize();
    end
endmodule
